// *** rtl/pci_cmd_status_pkg.sv ***
// Offsets, field positions and reset values of the command and status words
package pci_cmd_status_pkg;

  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;

  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0230;

  // Command word fields
  localparam int IO_DECODE_BIT = 0;
  localparam int MEM_DECODE_BIT = 1;
  localparam int INITIATOR_BIT = 2;
  localparam int WRITE_INVALIDATE_BIT = 4;
  localparam int PARITY_RESPONSE_BIT = 6;
  localparam int SYSTEM_FAULT_EN_BIT = 8;
  localparam logic [15:0] CMD_WRITABLE = 16'h0157;

  // Status word fields
  localparam int CAPS_LIST_BIT = 4;
  localparam int FAST_CLOCK_BIT = 5;
  localparam int B2B_TARGET_BIT = 7;
  localparam int MASTER_PARITY_BIT = 8;
  localparam int SELECT_SPEED_LSB = 9;
  localparam int SENT_TARGET_ABORT_BIT = 11;
  localparam int GOT_TARGET_ABORT_BIT = 12;
  localparam int GOT_MASTER_ABORT_BIT = 13;
  localparam int SENT_SYSTEM_FAULT_BIT = 14;
  localparam int SEEN_PARITY_BIT = 15;

  localparam logic CAPS_LIST_VALUE = 1'b1;
  localparam logic FAST_CLOCK_VALUE = 1'b1;
  localparam logic B2B_TARGET_VALUE = 1'b0;
  localparam logic [1:0] SELECT_SPEED_VALUE = 2'h1;

  // Sticky event slots inside the sticky bank
  localparam int EV_MASTER_PARITY = 0;
  localparam int EV_SENT_TARGET_ABORT = 1;
  localparam int EV_GOT_TARGET_ABORT = 2;
  localparam int EV_GOT_MASTER_ABORT = 3;
  localparam int EV_SENT_SYSTEM_FAULT = 4;
  localparam int EV_SEEN_PARITY = 5;
  localparam int EV_COUNT = 6;

  // Power state code of the fully on state
  localparam logic [1:0] POWER_D0 = 2'h0;

endpackage

// *** rtl/sticky_event_bank.sv ***
// Bank of sticky event flags, set by hardware and cleared by writing ones
`timescale 1ns/10ps
module sticky_event_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic [pci_cmd_status_pkg::EV_COUNT-1:0] setPulse,
  input wire logic clearWrite,
  input wire logic [pci_cmd_status_pkg::EV_COUNT-1:0] clearMask,
  output logic [pci_cmd_status_pkg::EV_COUNT-1:0] flags
);

  logic [pci_cmd_status_pkg::EV_COUNT-1:0] flags_q;
  logic [pci_cmd_status_pkg::EV_COUNT-1:0] flags_d;
  logic [pci_cmd_status_pkg::EV_COUNT-1:0] clearBits;

  assign clearBits = clearWrite ? clearMask : '0;
  // Set wins over a clear in the same cycle; zeros written leave a flag alone
  assign flags_d = (flags_q & ~clearBits) | setPulse;
  assign flags = flags_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// *** rtl/pci_command_status_regs.sv ***
// Command and status words of the configuration header with their gating
`timescale 1ns/10ps
module pci_command_status_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [15:0] cfgWriteData,
  output logic [15:0] cfgReadData,
  input wire logic [1:0] powerState,
  input wire logic romDecodeEnable,
  input wire logic sentTargetAbort,
  input wire logic gotTargetAbort,
  input wire logic gotMasterAbort,
  input wire logic masterParitySeen,
  input wire logic parityFaultSeen,
  input wire logic systemFaultRequest,
  output logic ioDecodeEnable,
  output logic memDecodeEnable,
  output logic romAccessEnable,
  output logic initiatorEnable,
  output logic writeInvalidatePermit,
  output logic parityFaultResponse,
  output logic systemFaultOut,
  output logic systemFaultOe
);

  logic [15:0] command_q;
  logic [15:0] command_d;
  logic [15:0] readData_q;
  logic [15:0] readData_d;
  logic [15:0] statusWord;
  logic [pci_cmd_status_pkg::EV_COUNT-1:0] eventSet;
  logic [pci_cmd_status_pkg::EV_COUNT-1:0] eventFlags;
  logic [pci_cmd_status_pkg::EV_COUNT-1:0] eventClear;
  logic hitCommand;
  logic hitStatus;
  logic inD0;
  logic faultSignal;

  // Pulls the sticky event bits out of a status-word image
  function automatic logic [pci_cmd_status_pkg::EV_COUNT-1:0] event_field(
    input logic [15:0] word
  );
    logic [pci_cmd_status_pkg::EV_COUNT-1:0] f;
    f = '0;
    f[pci_cmd_status_pkg::EV_MASTER_PARITY] = word[pci_cmd_status_pkg::MASTER_PARITY_BIT];
    f[pci_cmd_status_pkg::EV_SENT_TARGET_ABORT] =
      word[pci_cmd_status_pkg::SENT_TARGET_ABORT_BIT];
    f[pci_cmd_status_pkg::EV_GOT_TARGET_ABORT] =
      word[pci_cmd_status_pkg::GOT_TARGET_ABORT_BIT];
    f[pci_cmd_status_pkg::EV_GOT_MASTER_ABORT] =
      word[pci_cmd_status_pkg::GOT_MASTER_ABORT_BIT];
    f[pci_cmd_status_pkg::EV_SENT_SYSTEM_FAULT] =
      word[pci_cmd_status_pkg::SENT_SYSTEM_FAULT_BIT];
    f[pci_cmd_status_pkg::EV_SEEN_PARITY] = word[pci_cmd_status_pkg::SEEN_PARITY_BIT];
    return f;
  endfunction

  // Address decode of the two words
  assign hitCommand = cfgAddr == pci_cmd_status_pkg::CMD_OFFSET;
  assign hitStatus = cfgAddr == pci_cmd_status_pkg::STATUS_OFFSET;
  assign inD0 = powerState == pci_cmd_status_pkg::POWER_D0;

  // Only implemented command bits are stored; reserved ones stay zero
  assign command_d = (cfgWrite && hitCommand) ?
    (cfgWriteData & pci_cmd_status_pkg::CMD_WRITABLE) : command_q;

  // Enables derived from the command word; all zeros leaves only config access
  assign ioDecodeEnable = command_q[pci_cmd_status_pkg::IO_DECODE_BIT] && inD0;
  assign memDecodeEnable = command_q[pci_cmd_status_pkg::MEM_DECODE_BIT] && inD0;
  assign romAccessEnable = command_q[pci_cmd_status_pkg::MEM_DECODE_BIT] &&
    romDecodeEnable && inD0;
  assign initiatorEnable = command_q[pci_cmd_status_pkg::INITIATOR_BIT] && inD0;
  assign writeInvalidatePermit = command_q[pci_cmd_status_pkg::WRITE_INVALIDATE_BIT] &&
    initiatorEnable;
  assign parityFaultResponse = command_q[pci_cmd_status_pkg::PARITY_RESPONSE_BIT];

  // System fault is open drain and active low: drive zero only when enabled
  assign faultSignal = systemFaultRequest &&
    command_q[pci_cmd_status_pkg::SYSTEM_FAULT_EN_BIT];
  assign systemFaultOut = 1'b0;
  assign systemFaultOe = faultSignal;

  // Hardware events feeding the sticky bits
  assign eventSet[pci_cmd_status_pkg::EV_MASTER_PARITY] = masterParitySeen &&
    command_q[pci_cmd_status_pkg::PARITY_RESPONSE_BIT];
  assign eventSet[pci_cmd_status_pkg::EV_SENT_TARGET_ABORT] = sentTargetAbort;
  assign eventSet[pci_cmd_status_pkg::EV_GOT_TARGET_ABORT] = gotTargetAbort;
  assign eventSet[pci_cmd_status_pkg::EV_GOT_MASTER_ABORT] = gotMasterAbort;
  assign eventSet[pci_cmd_status_pkg::EV_SENT_SYSTEM_FAULT] = faultSignal;
  assign eventSet[pci_cmd_status_pkg::EV_SEEN_PARITY] = parityFaultSeen;

  assign eventClear = event_field(cfgWriteData);

  sticky_event_bank eventBank (
    .clk(clk),
    .reset(reset),
    .setPulse(eventSet),
    .clearWrite(cfgWrite && hitStatus),
    .clearMask(eventClear),
    .flags(eventFlags)
  );

  // Status image: fixed capability bits, sticky events, reserved zeros
  always_comb begin
    statusWord = 16'h0000;
    statusWord[pci_cmd_status_pkg::CAPS_LIST_BIT] = pci_cmd_status_pkg::CAPS_LIST_VALUE;
    statusWord[pci_cmd_status_pkg::FAST_CLOCK_BIT] =
      pci_cmd_status_pkg::FAST_CLOCK_VALUE;
    statusWord[pci_cmd_status_pkg::B2B_TARGET_BIT] =
      pci_cmd_status_pkg::B2B_TARGET_VALUE;
    statusWord[pci_cmd_status_pkg::SELECT_SPEED_LSB +: 2] =
      pci_cmd_status_pkg::SELECT_SPEED_VALUE;
    statusWord[pci_cmd_status_pkg::MASTER_PARITY_BIT] =
      eventFlags[pci_cmd_status_pkg::EV_MASTER_PARITY];
    statusWord[pci_cmd_status_pkg::SENT_TARGET_ABORT_BIT] =
      eventFlags[pci_cmd_status_pkg::EV_SENT_TARGET_ABORT];
    statusWord[pci_cmd_status_pkg::GOT_TARGET_ABORT_BIT] =
      eventFlags[pci_cmd_status_pkg::EV_GOT_TARGET_ABORT];
    statusWord[pci_cmd_status_pkg::GOT_MASTER_ABORT_BIT] =
      eventFlags[pci_cmd_status_pkg::EV_GOT_MASTER_ABORT];
    statusWord[pci_cmd_status_pkg::SENT_SYSTEM_FAULT_BIT] =
      eventFlags[pci_cmd_status_pkg::EV_SENT_SYSTEM_FAULT];
    statusWord[pci_cmd_status_pkg::SEEN_PARITY_BIT] =
      eventFlags[pci_cmd_status_pkg::EV_SEEN_PARITY];
  end

  // Read data is registered; other offsets read zero
  assign readData_d = !cfgRead ? readData_q :
    hitCommand ? command_q :
    hitStatus ? statusWord : 16'h0000;
  assign cfgReadData = readData_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      command_q <= pci_cmd_status_pkg::CMD_RESET;
      readData_q <= 16'h0000;
    end else begin
      command_q <= command_d;
      readData_q <= readData_d;
    end
  end

endmodule

// *** tb/pci_command_status_regs_assertions.sv ***
// Port assertions for the command and status register block
`timescale 1ns/10ps
module pci_command_status_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [15:0] cfgWriteData,
  input wire logic [15:0] cfgReadData,
  input wire logic [1:0] powerState,
  input wire logic romDecodeEnable,
  input wire logic gotMasterAbort,
  input wire logic systemFaultRequest,
  input wire logic ioDecodeEnable,
  input wire logic memDecodeEnable,
  input wire logic romAccessEnable,
  input wire logic initiatorEnable,
  input wire logic writeInvalidatePermit,
  input wire logic parityFaultResponse,
  input wire logic systemFaultOut,
  input wire logic systemFaultOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic inD0 = powerState == pci_cmd_status_pkg::POWER_D0;
  sequence statusRead;
    cfgRead && !cfgWrite && cfgAddr == pci_cmd_status_pkg::STATUS_OFFSET;
  endsequence
  sequence cmdWrite;
    cfgWrite && cfgAddr == pci_cmd_status_pkg::CMD_OFFSET;
  endsequence
  io_power_gate_a: assert property (ioDecodeEnable |-> inD0)
    else $error("io decode outside D0");
  master_power_gate_a: assert property (initiatorEnable |-> inD0)
    else $error("mastering outside D0");
  rom_decode_gate_a: assert property (romAccessEnable |-> romDecodeEnable && memDecodeEnable)
    else $error("rom decode without both enables");
  write_invalidate_gate_a: assert property (writeInvalidatePermit |-> initiatorEnable)
    else $error("write invalidate without mastering");
  fault_pin_gate_a: assert property (!systemFaultOut && (!systemFaultOe || systemFaultRequest))
    else $error("system fault pin driven without request");
  cmd_write_take_a: assert property (cmdWrite |=> parityFaultResponse == $past(cfgWriteData[6])
    && ioDecodeEnable == ($past(cfgWriteData[0]) && inD0)) else $error("command write not taken");
  status_fixed_bits_a: assert property (statusRead |=> cfgReadData[10:9] == 2'h1
    && cfgReadData[7:0] == 8'h30) else $error("status fixed bits wrong");
  event_latch_a: assert property (gotMasterAbort ##1 !cfgWrite ##1 statusRead |=> cfgReadData[13])
    else $error("master abort not latched");
  cmd_reserved_zero_a: assert property (cfgRead && cfgAddr == pci_cmd_status_pkg::CMD_OFFSET
    |=> (cfgReadData & ~pci_cmd_status_pkg::CMD_WRITABLE) == 16'h0000) else $error("reserved bit set");
endmodule
bind pci_command_status_regs pci_command_status_checker i_checker (.clk, .reset, .cfgWrite,
  .cfgRead, .cfgAddr, .cfgWriteData, .cfgReadData, .powerState, .romDecodeEnable, .gotMasterAbort,
  .systemFaultRequest, .ioDecodeEnable, .memDecodeEnable, .romAccessEnable, .initiatorEnable,
  .writeInvalidatePermit, .parityFaultResponse, .systemFaultOut, .systemFaultOe);

// *** tb/pci_host_model.sv ***
// Host bridge model issuing word configuration cycles
`timescale 1ns/10ps
module pci_host_model (
  input wire logic clk,
  output logic cfgWrite,
  output logic cfgRead,
  output logic [7:0] cfgAddr,
  output logic [15:0] cfgWriteData
);
  initial begin
    {cfgWrite, cfgRead, cfgAddr, cfgWriteData} = '0;
  end
  // Whole words only, strobe held for one clock, then lines scrambled
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data);
    @(negedge clk);
    cfgAddr = addr;
    cfgWriteData = data;
    cfgWrite = wr;
    cfgRead = !wr;
    @(negedge clk);
    cfgWrite = 1'b0;
    cfgRead = 1'b0;
    cfgAddr = ~addr;
    cfgWriteData = ~data;
  endtask
endmodule

// *** tb/test_pci_command_status_regs.sv ***
// Self-checking bench for the command and status register block
`timescale 1ns/10ps
module test_pci_command_status_regs;
  localparam logic [7:0] CMD = pci_cmd_status_pkg::CMD_OFFSET;
  localparam logic [7:0] STS = pci_cmd_status_pkg::STATUS_OFFSET;
  localparam logic [15:0] SRST = pci_cmd_status_pkg::STATUS_RESET;
  logic clk = 1'b0, reset = 1'b1, pend = 1'b0, romDecodeEnable = 1'b0;
  logic [1:0] powerState = 2'h0;
  logic [5:0] ev = 6'h00;
  logic cfgWrite, cfgRead, io, mem, rom, init, mwi, par, sfOut, sfOe;
  logic [7:0] cfgAddr;
  logic [15:0] cfgWriteData, cfgReadData;
  logic [15:0] expQ[$];
  int error_cnt = 0, n_checks = 0;
  int bitPos[6] = '{8, 11, 12, 13, 14, 15};
  initial forever #5 clk = ~clk;
  pci_host_model i_host (.clk, .cfgWrite, .cfgRead, .cfgAddr, .cfgWriteData);
  pci_command_status_regs i_dut (.clk, .reset, .cfgWrite, .cfgRead, .cfgAddr, .cfgWriteData,
    .cfgReadData, .powerState, .romDecodeEnable, .sentTargetAbort(ev[1]), .gotTargetAbort(ev[2]),
    .gotMasterAbort(ev[3]), .masterParitySeen(ev[0]), .parityFaultSeen(ev[5]),
    .systemFaultRequest(ev[4]), .ioDecodeEnable(io), .memDecodeEnable(mem), .romAccessEnable(rom),
    .initiatorEnable(init), .writeInvalidatePermit(mwi), .parityFaultResponse(par),
    .systemFaultOut(sfOut), .systemFaultOe(sfOe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    expQ.push_back(exp);
    i_host.access(1'b0, addr, 16'($urandom));
  endtask
  always @(posedge clk) pend <= cfgRead;
  always @(negedge clk) if (pend === 1'b1) check(cfgReadData, expQ.pop_front());
  initial begin
    logic [15:0] d;
    logic [7:0] a;
    void'($urandom(32'he6a1c1e6));
    repeat (12) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    rd(CMD, pci_cmd_status_pkg::CMD_RESET);
    rd(STS, SRST);
    check({10'h0, io, mem, rom, init, mwi, par}, 16'h0000);
    d = 16'($urandom);
    i_host.access(1'b1, CMD, d);
    rd(CMD, d & pci_cmd_status_pkg::CMD_WRITABLE);
    i_host.access(1'b1, CMD, 16'hffff);
    for (int p = 0; p < 4; p++) begin
      @(negedge clk);
      powerState = 2'(p);
      romDecodeEnable = 1'($urandom);
      #1 check({10'h0, io, mem, rom, init, mwi, par},
        (p == 0) ? {10'h0, 2'b11, romDecodeEnable, 3'b111} : 16'h0001);
    end
    @(negedge clk) powerState = 2'h0;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk) ev[i] = 1'b1;
      #1 check({15'h0, sfOe}, {15'h0, i == 4});
      @(negedge clk) ev[i] = 1'b0;
      rd(STS, SRST | (16'h1 << bitPos[i]));
      i_host.access(1'b1, STS, ~(16'h1 << bitPos[i]));
      rd(STS, SRST | (16'h1 << bitPos[i]));
      i_host.access(1'b1, STS, 16'h1 << bitPos[i]);
      rd(STS, SRST);
    end
    i_host.access(1'b1, CMD, 16'h0000);
    @(negedge clk) ev = 6'h11;
    #1 check({15'h0, sfOe}, 16'h0000);
    @(negedge clk) ev = 6'h00;
    rd(STS, SRST);
    a = 8'(8 + $urandom % 248);
    i_host.access(1'b1, a, 16'($urandom));
    rd(a, 16'h0000);
    rd(CMD, 16'h0000);
    i_host.access(1'b1, CMD, 16'h0157);
    @(negedge clk) ev = 6'h3e;
    @(negedge clk) begin
      ev = 6'h00;
      reset = 1'b1;
    end
    repeat (2) @(negedge clk);
    reset = 1'b0;
    #1 check({10'h0, io, mem, rom, init, mwi, par}, 16'h0000);
    rd(STS, SRST);
    rd(CMD, pci_cmd_status_pkg::CMD_RESET);
    repeat (3) @(negedge clk);
    summarize();
  end
  initial begin
    #20us;
    error_cnt++;
    summarize();
  end
endmodule
